//--- pkg/bcc_pkg.sv
package bcc_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_MASK   = 8'h08;
    localparam logic [7:0] OFF_CALIB  = 8'h0C;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int CTRL_DLL_DIS_N = 0;
    localparam int CTRL_FT_SEL    = 1;
    localparam int CTRL_WRAP_SEL  = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [2:0]        CTRL_RST  = 3'h7;
    localparam logic [ADDR_W-1:0] MASK_RST  = 16'hFFFF;
    localparam logic [15:0]       CALIB_RST = 16'h0040;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int DLL_RELOCK_CLOCKS = 1024;

    // ------------------------------------------------------------
    // Responses
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0]
    {
        CAL_IDLE = 2'b00,
        CAL_RUN  = 2'b01,
        CAL_DONE = 2'b10
    } bcc_cal_t;

    typedef struct packed
    {
        logic address_load_strobe;
        logic counter_increment_enable;
        logic counter_clear;
        logic counter_mask_select;
        logic restart_segment_n;
    } bcc_cnt_ctl_t;

endpackage

//--- rtl/bcc_top.sv
// How it works
// - Low dll_disable_n turns this port's DLL off.
// - flowthrough_select low gives flow-through output, high gives pipelined output.
// - Read/write select low writes the array, high reads it.
// - Ready goes low after DLL and impedance calibration finish; open-drain capable.
// - Near-full flag goes low one cycle before unmasked bits become all ones.
// - At max count with wrap low, next increment clears unmasked bits.
// - At max count with wrap high, next increment reloads mirror address.
// - Low restart_segment_n reloads the initially loaded address.
// - Master reset is active low, asynchronous, and resets the whole port.
// - All transfers happen on the rising port clock edge.
// - Toggling dll_disable_n resets only this port's DLL.
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/10ps
module bcc_top
    import bcc_pkg::*;
(
    input  wire logic                      CLK,            // Port clock
    input  wire logic                      RST_B,          // Sync reset, active low
    input  wire logic                      MASTER_RESET_N, // Async master reset
    input  wire logic [bcc_pkg::ADDR_W-1:0] ADDR,          // Address load value
    input  wire logic                      READ_WRITE_SEL, // Low write, high read
    input  wire logic                      ACCESS_VALID,   // Access this cycle
    input  wire bcc_pkg::bcc_cnt_ctl_t     CNT_CTL,        // Counter controls
    output logic [bcc_pkg::ADDR_W-1:0]     COUNTER_ADDR,   // Burst address
    output logic                           ARRAY_WRITE,    // Write strobe
    output logic                           ARRAY_READ,     // Read strobe
    output logic                           PIPELINED_MODE, // Pipelined timing
    output logic                           DLL_ENABLE,     // DLL running
    output logic                           READY_OUT,      // Ready level
    output logic                           READY_OE,       // Drive low when ready
    output logic                           COUNTER_NEAR_FULL_FLAG_N, // Near full
    input  wire logic                      S_AXI_AWVALID,  // AXI write address
    output logic                           S_AXI_AWREADY,
    input  wire logic [7:0]                S_AXI_AWADDR,
    input  wire logic                      S_AXI_WVALID,   // AXI write data
    output logic                           S_AXI_WREADY,
    input  wire logic [bcc_pkg::DATA_W-1:0] S_AXI_WDATA,
    input  wire logic [3:0]                S_AXI_WSTRB,
    output logic                           S_AXI_BVALID,   // AXI write response
    input  wire logic                      S_AXI_BREADY,
    output logic [1:0]                     S_AXI_BRESP,
    input  wire logic                      S_AXI_ARVALID,  // AXI read address
    output logic                           S_AXI_ARREADY,
    input  wire logic [7:0]                S_AXI_ARADDR,
    output logic                           S_AXI_RVALID,   // AXI read data
    input  wire logic                      S_AXI_RREADY,
    output logic [bcc_pkg::DATA_W-1:0]     S_AXI_RDATA,
    output logic [1:0]                     S_AXI_RRESP
);
    import bcc_pkg::*;

    // ------------------------------------------------------------
    // Reset merge
    // ------------------------------------------------------------
    // Async master reset is caught by two flops; release is synchronous
    logic       mr_s1_q;
    logic       mr_s2_q;
    always_ff @(posedge CLK or negedge MASTER_RESET_N)
    begin
        if (!MASTER_RESET_N)
        begin
            mr_s1_q <= 1'b0;
            mr_s2_q <= 1'b0;
        end
        else
        begin
            mr_s1_q <= 1'b1;
            mr_s2_q <= mr_s1_q;
        end
    end
    logic rst_n;
    assign rst_n = RST_B && mr_s2_q;

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic [2:0]        ctrl_q, ctrl_d;
    logic [ADDR_W-1:0] mask_q, mask_d;
    logic [15:0]       calib_q, calib_d;
    logic              aw_got_q, aw_got_d, w_got_q, w_got_d;
    logic [7:0]        awaddr_q, awaddr_d;
    logic [31:0]       wdata_q, wdata_d;
    logic [3:0]        wstrb_q, wstrb_d;
    logic              bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic              awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
    logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0]       rdata_q, rdata_d;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == OFF_CTRL) || (a == OFF_STATUS) || (a == OFF_MASK) || (a == OFF_CALIB);
    endfunction

    // Unmasked bits are one increment short of all ones
    function automatic logic pre_full(input logic [ADDR_W-1:0] c, input logic [ADDR_W-1:0] m);
        pre_full = ((c & m) != m) && ((((c & m) + 16'h0001) & m) == m);
    endfunction

    logic [ADDR_W-1:0] cnt_q, cnt_d, mirror_q, mirror_d;
    logic              flag_n_q, flag_n_d;
    logic              ready_q;
    bcc_cal_t          cal_q, cal_d;
    logic [15:0]       cal_cnt_q, cal_cnt_d;

    always_comb
    begin
        ctrl_d   = ctrl_q;
        mask_d   = mask_q;
        calib_d  = calib_q;
        aw_got_d = aw_got_q;
        w_got_d  = w_got_q;
        awaddr_d = awaddr_q;
        wdata_d  = wdata_q;
        wstrb_d  = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d  = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d  = rresp_q;
        rdata_d  = rdata_q;
        if (S_AXI_AWVALID && awready_q)
        begin
            aw_got_d = 1'b1;
            awaddr_d = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && wready_q)
        begin
            w_got_d = 1'b1;
            wdata_d = S_AXI_WDATA;
            wstrb_d = S_AXI_WSTRB;
        end
        if (aw_got_q && w_got_q)
        begin
            aw_got_d = 1'b0;
            w_got_d  = 1'b0;
            bvalid_d = 1'b1;
            bresp_d  = mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
            if (awaddr_q == OFF_CTRL && wstrb_q[0])
                ctrl_d = wdata_q[2:0];
            if (awaddr_q == OFF_MASK)
            begin
                if (wstrb_q[0]) mask_d[7:0]  = wdata_q[7:0];
                if (wstrb_q[1]) mask_d[15:8] = wdata_q[15:8];
            end
            if (awaddr_q == OFF_CALIB)
            begin
                if (wstrb_q[0]) calib_d[7:0]  = wdata_q[7:0];
                if (wstrb_q[1]) calib_d[15:8] = wdata_q[15:8];
            end
        end
        if (bvalid_q && S_AXI_BREADY)
            bvalid_d = 1'b0;
        if (rvalid_q && S_AXI_RREADY)
            rvalid_d = 1'b0;
        if (S_AXI_ARVALID && arready_q)
        begin
            rvalid_d = 1'b1;
            rresp_d  = mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
            case (S_AXI_ARADDR)
                OFF_CTRL:   rdata_d = {29'h0, ctrl_q};
                OFF_STATUS: rdata_d = {cnt_q, 12'h000, cal_q, flag_n_q, ready_q};
                OFF_MASK:   rdata_d = {16'h0000, mask_q};
                OFF_CALIB:  rdata_d = {16'h0000, calib_q};
                default:    rdata_d = 32'h0000_0000;
            endcase
        end
        // Readies are registered so every bus output leaves a flop
        awready_d = !aw_got_d && !bvalid_d;
        wready_d  = !w_got_d && !bvalid_d;
        arready_d = !rvalid_d;
    end

    always_ff @(posedge CLK)
    begin
        if (!rst_n)
        begin
            ctrl_q   <= CTRL_RST;
            mask_q   <= MASK_RST;
            calib_q  <= CALIB_RST;
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q  <= 32'h0000_0000;
            wstrb_q  <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q  <= RESP_OKAY;
            rdata_q  <= 32'h0000_0000;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            arready_q <= 1'b0;
        end
        else
        begin
            ctrl_q   <= ctrl_d;
            mask_q   <= mask_d;
            calib_q  <= calib_d;
            aw_got_q <= aw_got_d;
            w_got_q  <= w_got_d;
            awaddr_q <= awaddr_d;
            wdata_q  <= wdata_d;
            wstrb_q  <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q  <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q  <= rresp_d;
            rdata_q  <= rdata_d;
            awready_q <= awready_d;
            wready_q  <= wready_d;
            arready_q <= arready_d;
        end
    end

    assign S_AXI_AWREADY = awready_q;
    assign S_AXI_WREADY  = wready_q;
    assign S_AXI_BVALID  = bvalid_q;
    assign S_AXI_BRESP   = bresp_q;
    assign S_AXI_ARREADY = arready_q;
    assign S_AXI_RVALID  = rvalid_q;
    assign S_AXI_RDATA   = rdata_q;
    assign S_AXI_RRESP   = rresp_q;

    // ------------------------------------------------------------
    // DLL and calibration
    // ------------------------------------------------------------
    logic dll_en, dll_en_prev_q;
    assign dll_en = ctrl_q[CTRL_DLL_DIS_N];

    // A DLL edge restarts calibration only; counter and bus stay untouched
    always_comb
    begin
        cal_d     = cal_q;
        cal_cnt_d = cal_cnt_q;
        case (cal_q)
            CAL_IDLE:
            begin
                cal_d     = CAL_RUN;
                cal_cnt_d = 16'h0000;
            end
            CAL_RUN:
            begin
                cal_cnt_d = cal_cnt_q + 16'h0001;
                if (cal_cnt_q >= calib_q)
                    cal_d = CAL_DONE;
            end
            CAL_DONE:  cal_d = CAL_DONE;
            default:   cal_d = CAL_IDLE;
        endcase
        if (dll_en != dll_en_prev_q)
            cal_d = CAL_IDLE;
    end

    always_ff @(posedge CLK)
    begin
        if (!rst_n)
        begin
            cal_q         <= CAL_IDLE;
            cal_cnt_q     <= 16'h0000;
            dll_en_prev_q <= 1'b1;
        end
        else
        begin
            cal_q         <= cal_d;
            cal_cnt_q     <= cal_cnt_d;
            dll_en_prev_q <= dll_en;
        end
    end
    assign ready_q = (cal_q == CAL_DONE);

    // ------------------------------------------------------------
    // Burst counter
    // ------------------------------------------------------------
    logic [ADDR_W-1:0] inc, nxt_mask_full;
    logic              at_max;

    always_comb
    begin
        cnt_d    = cnt_q;
        mirror_d = mirror_q;
        inc      = ((cnt_q & mask_q) + 16'h0001) & mask_q;
        at_max   = ((cnt_q & mask_q) == mask_q);
        nxt_mask_full = (cnt_q & ~mask_q) | inc;
        if (CNT_CTL.counter_clear)
            cnt_d = 16'h0000;
        else if (CNT_CTL.address_load_strobe)
        begin
            cnt_d    = ADDR;
            mirror_d = ADDR;
        end
        else if (!CNT_CTL.restart_segment_n)
            cnt_d = mirror_q;
        else if (CNT_CTL.counter_increment_enable)
        begin
            if (at_max && !ctrl_q[CTRL_WRAP_SEL])
                cnt_d = cnt_q & ~mask_q;
            else if (at_max)
                cnt_d = mirror_q;
            else
                cnt_d = nxt_mask_full;
        end
        // Flag leads the increment that completes all ones by a cycle
        flag_n_d = !pre_full(cnt_d, mask_d);
    end

    always_ff @(posedge CLK)
    begin
        if (!rst_n)
        begin
            cnt_q    <= 16'h0000;
            mirror_q <= 16'h0000;
            flag_n_q <= 1'b1;
        end
        else
        begin
            cnt_q    <= cnt_d;
            mirror_q <= mirror_d;
            flag_n_q <= flag_n_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (!rst_n)
        begin
            COUNTER_ADDR   <= 16'h0000;
            ARRAY_WRITE    <= 1'b0;
            ARRAY_READ     <= 1'b0;
            PIPELINED_MODE <= 1'b1;
            DLL_ENABLE     <= 1'b0;
            READY_OUT      <= 1'b1;
            READY_OE       <= 1'b0;
            COUNTER_NEAR_FULL_FLAG_N <= 1'b1;
        end
        else
        begin
            COUNTER_ADDR   <= cnt_q;
            ARRAY_WRITE    <= ACCESS_VALID && !READ_WRITE_SEL;
            ARRAY_READ     <= ACCESS_VALID && READ_WRITE_SEL;
            PIPELINED_MODE <= ctrl_q[CTRL_FT_SEL];
            DLL_ENABLE     <= dll_en && (cal_q != CAL_IDLE);
            READY_OUT      <= !ready_q;
            READY_OE       <= ready_q;
            COUNTER_NEAR_FULL_FLAG_N <= flag_n_q;
        end
    end

endmodule

//--- verification/bcc_props.sv
`timescale 1ns/10ps
module bcc_props
    import bcc_pkg::*;
(
    input wire logic                       CLK,                      // clock
    input wire logic                       RST_B,                    // sync reset
    input wire logic                       MASTER_RESET_N,           // master reset
    input wire logic [bcc_pkg::ADDR_W-1:0] ADDR,                     // load value
    input wire logic                       READ_WRITE_SEL,           // low write
    input wire logic                       ACCESS_VALID,             // access
    input wire bcc_pkg::bcc_cnt_ctl_t      CNT_CTL,                  // counter controls
    input wire logic [bcc_pkg::ADDR_W-1:0] COUNTER_ADDR,             // burst address
    input wire logic                       ARRAY_WRITE,              // write strobe
    input wire logic                       ARRAY_READ,               // read strobe
    input wire logic                       PIPELINED_MODE,           // output timing
    input wire logic                       DLL_ENABLE,               // DLL on
    input wire logic                       READY_OUT,                // ready level
    input wire logic                       READY_OE,                 // ready drive
    input wire logic                       COUNTER_NEAR_FULL_FLAG_N  // near full
);
    logic [2:0] live_q;
    logic [2:0] live_d;
    logic       live;

    // Master reset leaves through two sync flops, so wait three clean edges
    always_comb live_d = {live_q[1:0], RST_B & MASTER_RESET_N};
    always_ff @(posedge CLK) live_q <= live_d;
    assign live = (&live_q) & RST_B & MASTER_RESET_N;

    default clocking cb @(posedge CLK); endclocking

    AST_WRITE: assert property (disable iff (!live)
        ACCESS_VALID && !READ_WRITE_SEL |=> ARRAY_WRITE && !ARRAY_READ) else $error("write strobe missing");
    AST_READ: assert property (disable iff (!live)
        ACCESS_VALID && READ_WRITE_SEL |=> ARRAY_READ && !ARRAY_WRITE) else $error("read strobe missing");
    AST_IDLE: assert property (disable iff (!live)
        !ACCESS_VALID |=> !ARRAY_READ && !ARRAY_WRITE) else $error("strobe without access");
    AST_READY_OD: assert property (disable iff (!RST_B)
        READY_OE |-> !READY_OUT) else $error("ready driven high");
    AST_READY_RST: assert property (disable iff (!MASTER_RESET_N)
        !RST_B |=> READY_OUT && !READY_OE) else $error("ready low in reset");
    AST_RST_OUT: assert property (disable iff (!MASTER_RESET_N)
        !RST_B |=> PIPELINED_MODE && !DLL_ENABLE && COUNTER_NEAR_FULL_FLAG_N && COUNTER_ADDR == '0)
        else $error("bad reset outputs");
    AST_MASTER_RESET_N: assert property (disable iff (!RST_B)
        $fell(MASTER_RESET_N) |-> ##[0:3] (READY_OUT && !DLL_ENABLE)) else $error("master reset ignored");
    AST_CLEAR: assert property (disable iff (!live)
        CNT_CTL.counter_clear |-> ##2 COUNTER_ADDR == '0) else $error("counter not cleared");
    AST_LOAD: assert property (disable iff (!live)
        CNT_CTL.address_load_strobe && !CNT_CTL.counter_clear |-> ##2 COUNTER_ADDR == $past(ADDR, 2))
        else $error("counter not loaded");

    COV_FLAG: cover property (disable iff (!live) $fell(COUNTER_NEAR_FULL_FLAG_N));
    COV_WRITE: cover property (disable iff (!live) ARRAY_WRITE);
    COV_READY: cover property (disable iff (!live) $fell(READY_OUT));
endmodule

bind bcc_top bcc_props u_props (.*);

//--- verification/bcc_host_model.sv
`timescale 1ns/10ps
module bcc_host_model
    import bcc_pkg::*;
(
    input  wire logic                   CLK,            // port clock
    output logic                        MASTER_RESET_N, // master reset
    output logic [bcc_pkg::ADDR_W-1:0]  ADDR,           // load value
    output logic                        READ_WRITE_SEL, // low write
    output logic                        ACCESS_VALID,   // access
    output bcc_pkg::bcc_cnt_ctl_t       CNT_CTL         // counter controls
);
    localparam bcc_cnt_ctl_t IDLE = 5'h01;

    initial
    begin
        ADDR = 16'h0000;
        READ_WRITE_SEL = 1'h1;
        ACCESS_VALID = 1'h0;
        CNT_CTL = IDLE;
        MASTER_RESET_N = 1'h0;
        repeat (4) @(posedge CLK);
        MASTER_RESET_N <= 1'h1;
    end

    // All controls move just after a rising edge
    task automatic ctl(input bcc_cnt_ctl_t v, input int n);
        @(posedge CLK);
        CNT_CTL <= v;
        repeat (n) @(posedge CLK);
        CNT_CTL <= IDLE;
    endtask

    // Released address bus shows the inverse, not the last value
    task automatic load(input logic [15:0] a);
        @(posedge CLK);
        ADDR <= a;
        CNT_CTL <= 5'h11;
        @(posedge CLK);
        ADDR <= ~a;
        CNT_CTL <= IDLE;
    endtask

    task automatic acc(input logic rw);
        @(posedge CLK);
        ACCESS_VALID <= 1'h1;
        READ_WRITE_SEL <= rw;
        @(posedge CLK);
        ACCESS_VALID <= 1'h0;
        READ_WRITE_SEL <= ~rw;
    endtask

    task automatic mreset();
        @(posedge CLK);
        MASTER_RESET_N <= 1'h0;
        repeat (3) @(posedge CLK);
        MASTER_RESET_N <= 1'h1;
    endtask

    task automatic relock();
        repeat (DLL_RELOCK_CLOCKS) @(posedge CLK);
    endtask
endmodule

//--- verification/test_dual_port_burst_counter_ctrl.sv
`timescale 1ns/10ps
module test_dual_port_burst_counter_ctrl;
    import bcc_pkg::*;
    logic         clk = 1'h0;
    logic         rst_b = 1'h0;
    logic         master_reset_n_n, rw, av, wr_s, rd_s, pipe, dll, rdy, rdy_oe, nf_n, awr, wrdy, bv, arr, rv;
    logic         awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0, nf_q = 1'h1;
    logic [15:0]  addr, caddr;
    logic [15:0]  flag_at = 16'h0000;
    logic [7:0]   awa = 8'h00, ara = 8'h00;
    logic [31:0]  wd = 32'h0000_0000, rd_d;
    logic [3:0]   strb = 4'hF;
    logic [1:0]   bresp, rresp;
    bcc_cnt_ctl_t ctl;
    int           fail_count = 0, n_compared = 0;

    always #(CLK_PERIOD_NS / 2) clk = ~clk;

    bcc_host_model host (.CLK(clk), .MASTER_RESET_N(master_reset_n_n), .ADDR(addr), .READ_WRITE_SEL(rw),
        .ACCESS_VALID(av), .CNT_CTL(ctl));
    bcc_top dut (.CLK(clk), .RST_B(rst_b), .MASTER_RESET_N(master_reset_n_n), .ADDR(addr), .READ_WRITE_SEL(rw),
        .ACCESS_VALID(av), .CNT_CTL(ctl), .COUNTER_ADDR(caddr), .ARRAY_WRITE(wr_s), .ARRAY_READ(rd_s),
        .PIPELINED_MODE(pipe), .DLL_ENABLE(dll), .READY_OUT(rdy), .READY_OE(rdy_oe),
        .COUNTER_NEAR_FULL_FLAG_N(nf_n), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa),
        .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_WDATA(wd), .S_AXI_WSTRB(strb), .S_AXI_BVALID(bv),
        .S_AXI_BREADY(br), .S_AXI_BRESP(bresp), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
        .S_AXI_ARADDR(ara), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .S_AXI_RDATA(rd_d), .S_AXI_RRESP(rresp));

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'h0;
        w_ok = 1'h0;
        @(posedge clk);
        awv <= 1'h1;
        wv <= 1'h1;
        awa <= a;
        wd <= d;
        br <= 1'h1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge clk);
            aw_ok = aw_ok | awr;
            w_ok = w_ok | wrdy;
            awv <= ~aw_ok;
            wv <= ~w_ok;
        end
        while (bv !== 1'h1) @(posedge clk);
        chk("bresp", 32'(er), 32'(bresp));
        br <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge clk);
        arv <= 1'h1;
        ara <= a;
        rr <= 1'h1;
        do @(posedge clk); while (arr !== 1'h1);
        arv <= 1'h0;
        do @(posedge clk); while (rv !== 1'h1);
        chk("rdata", e, rd_d);
        chk("rresp", 32'(er), 32'(rresp));
        rr <= 1'h0;
    endtask

    // Counter shows on the port two edges after its controls
    task automatic cnt(input logic [15:0] e);
        repeat (2) @(posedge clk);
        chk("counter", 32'(e), 32'(caddr));
    endtask

    task automatic wait_rdy(input logic lvl);
        for (int i = 0; i < 3000 && rdy !== lvl; i++) @(posedge clk);
        chk("ready", 32'(lvl), 32'(rdy));
    endtask

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    always @(posedge clk)
    begin
        if (nf_q === 1'h1 && nf_n === 1'h0)
            flag_at <= caddr;
        nf_q <= nf_n;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        fail_count++;
        test_done();
    end

    initial
    begin
        repeat (16) @(posedge clk);
        rst_b <= 1'h1;
        chk("pipelined", 32'h1, 32'(pipe));
        chk("ready", 32'h1, 32'(rdy));
        rd(OFF_CTRL, 32'(CTRL_RST), RESP_OKAY);
        rd(OFF_MASK, 32'(MASK_RST), RESP_OKAY);
        rd(OFF_CALIB, 32'(CALIB_RST), RESP_OKAY);
        rd(8'h10, 32'h0000_0000, RESP_SLVERR);
        wr(8'h10, 32'hFFFF_FFFF, RESP_SLVERR);
        strb <= 4'h2;
        wr(OFF_MASK, 32'h0000_0012, RESP_OKAY);
        rd(OFF_MASK, 32'h0000_00FF, RESP_OKAY);
        strb <= 4'hF;
        wr(OFF_MASK, 32'h0000_FFFF, RESP_OKAY);
        wr(OFF_CALIB, 32'h0000_0004, RESP_OKAY);
        wait_rdy(1'h0);
        chk("ready drive", 32'h1, 32'(rdy_oe));
        $display("test 1 done");
        host.load(16'h1234);
        cnt(16'h1234);
        wr(OFF_CTRL, 32'h0000_0000, RESP_OKAY);
        repeat (2) @(posedge clk);
        chk("pipelined", 32'h0, 32'(pipe));
        chk("dll", 32'h0, 32'(dll));
        wait_rdy(1'h1);
        wr(OFF_CTRL, 32'h0000_0007, RESP_OKAY);
        host.relock();
        wait_rdy(1'h0);
        chk("dll", 32'h1, 32'(dll));
        cnt(16'h1234);
        $display("test 2 done");
        wr(OFF_CTRL, 32'h0000_0003, RESP_OKAY);
        host.load(16'hFFFC);
        host.ctl(5'h09, 3);
        cnt(16'hFFFF);
        chk("flag place", 32'h0000_FFFE, 32'(flag_at));
        host.ctl(5'h09, 1);
        cnt(16'h0000);
        wr(OFF_CTRL, 32'h0000_0007, RESP_OKAY);
        host.load(16'hFFFD);
        host.ctl(5'h09, 3);
        cnt(16'hFFFD);
        $display("test 3 done");
        host.load(16'h0100);
        host.ctl(5'h09, 5);
        cnt(16'h0105);
        host.ctl(5'h00, 1);
        cnt(16'h0100);
        host.ctl(5'h15, 1);
        cnt(16'h0000);
        host.acc(1'h0);
        @(posedge clk);
        chk("write strobe", 32'h1, 32'(wr_s));
        host.acc(1'h1);
        @(posedge clk);
        chk("read strobe", 32'h1, 32'(rd_s));
        $display("test 4 done");
        wr(OFF_CTRL, 32'h0000_0000, RESP_OKAY);
        host.load(16'h5555);
        host.mreset();
        repeat (3) @(posedge clk);
        chk("ready", 32'h1, 32'(rdy));
        chk("counter", 32'h0, 32'(caddr));
        rd(OFF_CTRL, 32'(CTRL_RST), RESP_OKAY);
        rd(OFF_STATUS, 32'h0000_0006, RESP_OKAY);
        $display("test 5 done");
        test_done();
    end
endmodule
